// ==== dtd_consts.vh ====
// Size encodings, field positions and timing constants for the data transfer decoder.
`ifndef DTD_CONSTS_VH
`define DTD_CONSTS_VH
`define DTD_INSN_W 16
`define DTD_DATA_W 32
`define DTD_RN_HI 11
`define DTD_RN_LO 8
`define DTD_RM_HI 7
`define DTD_RM_LO 4
`define DTD_SIZE_B 2'h0
`define DTD_SIZE_W 2'h1
`define DTD_SIZE_L 2'h2
`define DTD_SWAPW_CYCLES 2'h2
`define DTD_LOAD_USE_CYCLES 2'h1
`endif

// ==== dtd_decoder.v ====
// Decode and execute stage for the data transfer class of the 16-bit instruction set.
//
// Function
// - Every instruction is one 16-bit halfword.
// - Four-bit source and destination register fields.
// - Stall while fetch contends with data access.
// - Interlock when next insn uses load destination.
// - Move immediate sign-extends eight bits, one cycle.
// - PC-relative word load: disp times two.
// - PC-relative longword load: disp times four.
// - Pre-decrement store updates address before writing.
// - Post-increment load adds size after reading, when source differs from destination.
// - Displacement longword store: disp times four.
// - Indexed loads use register zero plus source.
// - Base-relative store scales disp by size.
// - Effective address op writes register zero only.
// - Prefetch requests a cache line, one cycle.
// - Extract takes middle 32 bits of pair.
// - Data transfers leave the flag bit unchanged.
`timescale 1ns/10ps
`include "dtd_consts.vh"

module dtd_decoder
#(
	parameter DATA_W = `DTD_DATA_W
)
(
	// Clock and reset.
	input wire clock,
	input wire srst,
	// Instruction fetch side.
	input wire insn_valid,
	input wire [15:0] insn,
	input wire [31:0] pc,
	output reg insn_taken_q,
	// Register file read data and status.
	input wire [31:0] src_val,
	input wire [31:0] dst_val,
	input wire [31:0] register_zero_val,
	input wire [31:0] global_base_reg,
	input wire status_flag,
	output reg [3:0] source_reg_field_q,
	output reg [3:0] dest_reg_field_q,
	// Memory stage.
	input wire fetch_contend,
	input wire [31:0] mem_rdata,
	input wire mem_rvalid,
	output reg mem_req_q,
	output reg mem_we_q,
	output reg [1:0] mem_size_q,
	output reg [31:0] mem_addr_q,
	output reg [31:0] mem_wdata_q,
	output reg prefetch_q,
	// Register write-back.
	output reg wb_en_q,
	output reg [3:0] wb_idx_q,
	output reg [31:0] wb_data_q,
	output reg upd_en_q,
	output reg [3:0] upd_idx_q,
	output reg [31:0] upd_data_q,
	output reg flag_we_q,
	output reg illegal_q,
	output reg stall_q
);

	// ------------------------------------------------------------
	// States
	// ------------------------------------------------------------
	localparam ST_IDLE = 2'h0;
	localparam ST_LOAD = 2'h1;
	localparam ST_SWAPW = 2'h2;

	reg [1:0] state_q;
	reg [1:0] state_d;
	reg [3:0] ld_dst_q;
	reg [1:0] ld_size_q;
	reg ld_sext_q;
	reg ld_pending_q;
	reg [31:0] swap_q;

	wire [3:0] op_hi = insn[15:12];
	wire [3:0] op_lo = insn[3:0];
	wire [3:0] rn = insn[`DTD_RN_HI:`DTD_RN_LO];
	wire [3:0] rm = insn[`DTD_RM_HI:`DTD_RM_LO];
	wire [7:0] d8 = insn[7:0];
	wire [3:0] d4 = insn[3:0];
	wire [31:0] d8x2 = {23'h000000, d8, 1'b0};
	wire [31:0] d8x4 = {22'h000000, d8, 2'h0};

	// Load-use hazard: next insn names the pending load destination, or that destination is register zero.
	wire uses_ld = ld_pending_q && (rn == ld_dst_q || rm == ld_dst_q || ld_dst_q == 4'h0);
	wire busy = (state_q != ST_IDLE) || fetch_contend || uses_ld;
	wire go = insn_valid && !busy;

	// ------------------------------------------------------------
	// Decode
	// ------------------------------------------------------------
	reg dv;
	reg d_req;
	reg d_we;
	reg [1:0] d_size;
	reg [31:0] d_addr;
	reg [31:0] d_wdata;
	reg d_load;
	reg d_sext;
	reg [3:0] d_ldst;
	reg d_wb;
	reg [3:0] d_wbidx;
	reg [31:0] d_wbdata;
	reg d_upd;
	reg [3:0] d_updidx;
	reg [31:0] d_upddata;
	reg d_cache_prefetch_op;
	reg d_swapw;
	reg [31:0] step;

	// Size-dependent step of 1, 2 or 4 bytes.
	always @*
	begin
		case (op_lo[1:0])
			2'h0: step = 32'h00000001;
			2'h1: step = 32'h00000002;
			default: step = 32'h00000004;
		endcase
	end

	// Combinational decode of one halfword into a memory and write-back plan.
	always @*
	begin
		dv = 1'b1;
		d_req = 1'b0;
		d_we = 1'b0;
		d_size = op_lo[1:0];
		d_addr = 32'h00000000;
		d_wdata = src_val;
		d_load = 1'b0;
		d_sext = 1'b1;
		d_ldst = rn;
		d_wb = 1'b0;
		d_wbidx = rn;
		d_wbdata = 32'h00000000;
		d_upd = 1'b0;
		d_updidx = rn;
		d_upddata = 32'h00000000;
		d_cache_prefetch_op = 1'b0;
		d_swapw = 1'b0;
		case (op_hi)
			4'he:
			begin
				d_wb = 1'b1;
				d_wbdata = {{24{d8[7]}}, d8};
			end
			4'h9:
			begin
				d_req = 1'b1;
				d_load = 1'b1;
				d_size = `DTD_SIZE_W;
				d_addr = pc + d8x2;
			end
			4'hd:
			begin
				d_req = 1'b1;
				d_load = 1'b1;
				d_size = `DTD_SIZE_L;
				d_addr = pc + d8x4;
			end
			4'h1:
			begin
				d_req = 1'b1;
				d_we = 1'b1;
				d_size = `DTD_SIZE_L;
				d_addr = dst_val + {26'h0000000, d4, 2'h0};
			end
			4'h5:
			begin
				d_req = 1'b1;
				d_load = 1'b1;
				d_size = `DTD_SIZE_L;
				d_addr = src_val + {26'h0000000, d4, 2'h0};
			end
			4'h2:
			begin
				if (op_lo[3:2] == 2'h0 && op_lo[1:0] != 2'h3)
				begin
					d_req = 1'b1;
					d_we = 1'b1;
					d_addr = dst_val;
				end
				else if (op_lo[3:2] == 2'h1 && op_lo[1:0] != 2'h3)
				begin
					d_req = 1'b1;
					d_we = 1'b1;
					d_addr = dst_val - step;
					d_upd = 1'b1;
					d_upddata = dst_val - step;
				end
				else if (op_lo == 4'hd)
				begin
					d_wb = 1'b1;
					d_wbdata = {src_val[15:0], dst_val[31:16]};
				end
				else
					dv = 1'b0;
			end
			4'h6:
			begin
				if (op_lo[3:2] == 2'h0 && op_lo[1:0] != 2'h3)
				begin
					d_req = 1'b1;
					d_load = 1'b1;
					d_addr = src_val;
				end
				else if (op_lo == 4'h3)
				begin
					d_wb = 1'b1;
					d_wbdata = src_val;
				end
				else if (op_lo[3:2] == 2'h1 && op_lo[1:0] != 2'h3)
				begin
					d_req = 1'b1;
					d_load = 1'b1;
					d_addr = src_val;
					d_upd = (rm != rn);
					d_updidx = rm;
					d_upddata = src_val + step;
				end
				else if (op_lo == 4'h8)
				begin
					d_wb = 1'b1;
					d_wbdata = {src_val[31:16], src_val[7:0], src_val[15:8]};
				end
				else if (op_lo == 4'h9)
					d_swapw = 1'b1;
				else
					dv = 1'b0;
			end
			4'h0:
			begin
				if (op_lo[3:2] == 2'h1 && op_lo[1:0] != 2'h3)
				begin
					d_req = 1'b1;
					d_we = 1'b1;
					d_addr = register_zero_val + dst_val;
				end
				else if (op_lo[3:2] == 2'h3 && op_lo[1:0] != 2'h3)
				begin
					d_req = 1'b1;
					d_load = 1'b1;
					d_addr = register_zero_val + src_val;
				end
				else if (insn[7:0] == 8'h29)
				begin
					d_wb = 1'b1;
					d_wbdata = {31'h00000000, status_flag};
				end
				else if (insn[7:0] == 8'h83)
				begin
					d_cache_prefetch_op = 1'b1;
					d_addr = dst_val;
				end
				else
					dv = 1'b0;
			end
			4'h8:
			begin
				d_size = insn[9:8];
				// Only byte and word sizes exist in this group; the rest is not a transfer.
				d_req = (insn[11:10] == 2'h0 || insn[11:10] == 2'h1) && !insn[9];
				d_we = (insn[11:10] == 2'h0);
				d_load = (insn[11:10] == 2'h1);
				d_wdata = register_zero_val;
				d_ldst = 4'h0;
				d_addr = src_val + ({28'h0000000, d4} << insn[9:8]);
				dv = d_req;
			end
			4'hc:
			begin
				d_size = insn[9:8];
				d_wdata = register_zero_val;
				d_ldst = 4'h0;
				if (insn[11:8] == 4'h7)
				begin
					d_wb = 1'b1;
					d_wbidx = 4'h0;
					d_wbdata = pc + d8x4;
				end
				else if (insn[11:10] == 2'h0 && insn[9:8] != 2'h3)
				begin
					d_req = 1'b1;
					d_we = 1'b1;
					d_addr = global_base_reg + ({24'h000000, d8} << insn[9:8]);
				end
				else if (insn[11:10] == 2'h1 && insn[9:8] != 2'h3)
				begin
					d_req = 1'b1;
					d_load = 1'b1;
					d_addr = global_base_reg + ({24'h000000, d8} << insn[9:8]);
				end
				else
					dv = 1'b0;
			end
			default: dv = 1'b0;
		endcase
		d_sext = (d_size != `DTD_SIZE_L);
	end

	// Sign extension of returning byte and word load data; longwords pass through.
	reg [31:0] ld_ext;
	always @*
	begin
		case (ld_size_q)
			`DTD_SIZE_B: ld_ext = {{24{mem_rdata[7]}}, mem_rdata[7:0]};
			`DTD_SIZE_W: ld_ext = {{16{mem_rdata[15]}}, mem_rdata[15:0]};
			default: ld_ext = mem_rdata;
		endcase
		if (!ld_sext_q)
			ld_ext = mem_rdata;
	end

	// Next state.
	always @*
	begin
		state_d = state_q;
		case (state_q)
			ST_IDLE:
			begin
				if (go && dv && d_swapw)
					state_d = ST_SWAPW;
				else if (go && dv && d_load)
					state_d = ST_LOAD;
			end
			ST_LOAD:
			begin
				if (mem_rvalid)
					state_d = ST_IDLE;
			end
			ST_SWAPW: state_d = ST_IDLE;
			default: state_d = ST_IDLE;
		endcase
	end

	// ------------------------------------------------------------
	// Registered outputs
	// ------------------------------------------------------------
	always @(posedge clock)
	begin
		if (srst)
		begin
			state_q <= ST_IDLE;
			insn_taken_q <= 1'b0;
			source_reg_field_q <= 4'h0;
			dest_reg_field_q <= 4'h0;
			mem_req_q <= 1'b0;
			mem_we_q <= 1'b0;
			mem_size_q <= 2'h0;
			mem_addr_q <= 32'h00000000;
			mem_wdata_q <= 32'h00000000;
			prefetch_q <= 1'b0;
			wb_en_q <= 1'b0;
			wb_idx_q <= 4'h0;
			wb_data_q <= 32'h00000000;
			upd_en_q <= 1'b0;
			upd_idx_q <= 4'h0;
			upd_data_q <= 32'h00000000;
			flag_we_q <= 1'b0;
			illegal_q <= 1'b0;
			stall_q <= 1'b0;
			ld_dst_q <= 4'h0;
			ld_size_q <= 2'h0;
			ld_sext_q <= 1'b0;
			ld_pending_q <= 1'b0;
			swap_q <= 32'h00000000;
		end
		else
		begin
			state_q <= state_d;
			insn_taken_q <= go;
			stall_q <= insn_valid && busy;
			flag_we_q <= 1'b0;
			mem_req_q <= go && dv && d_req;
			mem_we_q <= d_we;
			mem_size_q <= d_size;
			mem_addr_q <= d_addr;
			mem_wdata_q <= d_wdata;
			prefetch_q <= go && dv && d_cache_prefetch_op;
			illegal_q <= go && !dv;
			upd_en_q <= go && dv && d_upd;
			upd_idx_q <= d_updidx;
			upd_data_q <= d_upddata;
			wb_en_q <= go && dv && d_wb;
			wb_idx_q <= d_wbidx;
			wb_data_q <= d_wbdata;
			if (go)
			begin
				source_reg_field_q <= rm;
				dest_reg_field_q <= rn;
			end
			if (go && dv && d_load)
			begin
				ld_dst_q <= d_ldst;
				ld_size_q <= d_size;
				ld_sext_q <= d_sext;
				ld_pending_q <= 1'b1;
			end
			if (go && dv && d_swapw)
			begin
				swap_q <= {src_val[15:0], src_val[31:16]};
			end
			// The swap's destination was captured when it was taken; the fetch side may have moved on.
			if (state_q == ST_SWAPW)
			begin
				wb_en_q <= 1'b1;
				wb_idx_q <= dest_reg_field_q;
				wb_data_q <= swap_q;
			end
			if (state_q == ST_LOAD && mem_rvalid)
			begin
				wb_en_q <= 1'b1;
				wb_idx_q <= ld_dst_q;
				wb_data_q <= ld_ext;
				ld_pending_q <= 1'b0;
			end
		end
	end

endmodule

// ==== dtd_props.sv ====
// Concurrent checks on the ports of the data transfer decoder.
`timescale 1ns/10ps
module dtd_props (
	// Clock and reset.
	input wire clock,
	input wire srst,
	// Fetch side and operands.
	input wire insn_valid,
	input wire [15:0] insn,
	input wire [31:0] pc,
	input wire [31:0] src_val,
	input wire [31:0] dst_val,
	input wire status_flag,
	input wire fetch_contend,
	// Decoder outputs.
	input wire insn_taken_q,
	input wire stall_q,
	input wire mem_req_q,
	input wire mem_we_q,
	input wire [31:0] mem_addr_q,
	input wire prefetch_q,
	input wire wb_en_q,
	input wire [3:0] wb_idx_q,
	input wire [31:0] wb_data_q,
	input wire upd_en_q,
	input wire flag_we_q
);
	default clocking cb @(posedge clock); endclocking
	default disable iff (srst);

	// -----------------------------------------------------------
	// Assertions
	// -----------------------------------------------------------
	// Checks gated by insn_taken_q tie an output to the instruction taken one edge earlier.
	a_imm_sign_ext: assert property (insn_taken_q && $past(insn[15:12]) == 4'he |->
		wb_en_q && wb_data_q == {{24{$past(insn[7])}}, $past(insn[7:0])}) else $error("imm sign extension");
	a_dest_field_idx: assert property (insn_taken_q && $past(insn[15:12]) == 4'he |->
		wb_idx_q == $past(insn[11:8])) else $error("imm destination index");
	a_pc_long_addr: assert property (insn_taken_q && $past(insn[15:12]) == 4'hd |->
		mem_req_q && !mem_we_q && mem_addr_q == $past(pc) + {$past(insn[7:0]), 2'h0}) else $error("pc long addr");
	a_predec_long: assert property (insn_taken_q && ($past(insn) & 16'hf00f) == 16'h2006 |->
		mem_we_q && upd_en_q && mem_addr_q == $past(dst_val) - 32'h4) else $error("predec addr");
	a_flag_kept: assert property (!flag_we_q) else $error("flag written");
	a_flag_move: assert property (insn_taken_q && ($past(insn) & 16'hf0ff) == 16'h0029 |->
		wb_data_q == {31'h0, $past(status_flag)}) else $error("flag move value");
	a_cache_prefetch_op_no_write: assert property (prefetch_q |-> !wb_en_q && !upd_en_q && !mem_we_q) else $error("cache_prefetch_op wrote");
	a_swapw_two_cyc: assert property (insn_taken_q && ($past(insn) & 16'hf00f) == 16'h6009 |->
		!wb_en_q ##1 wb_en_q && wb_data_q == {$past(src_val[15:0], 2), $past(src_val[31:16], 2)})
		else $error("word swap timing");
	a_contend_stall: assert property (insn_valid && fetch_contend |=> stall_q && !insn_taken_q)
		else $error("contention not stalled");

	// Main scenarios reached.
	c_imm: cover property (insn_taken_q && $past(insn[15:12]) == 4'he);
	c_swapw: cover property (insn_taken_q && ($past(insn) & 16'hf00f) == 16'h6009);
	c_stall: cover property (stall_q);
endmodule

bind dtd_decoder dtd_props props_u (.clock(clock), .srst(srst), .insn_valid(insn_valid), .insn(insn), .pc(pc),
	.src_val(src_val), .dst_val(dst_val), .status_flag(status_flag), .fetch_contend(fetch_contend),
	.insn_taken_q(insn_taken_q), .stall_q(stall_q), .mem_req_q(mem_req_q), .mem_we_q(mem_we_q),
	.mem_addr_q(mem_addr_q), .prefetch_q(prefetch_q), .wb_en_q(wb_en_q), .wb_idx_q(wb_idx_q),
	.wb_data_q(wb_data_q), .upd_en_q(upd_en_q), .flag_we_q(flag_we_q));

// ==== dtd_tb.sv ====
// Self-checking bench for the data transfer decoder.
`timescale 1ns/10ps
module testbench;
	reg clock, srst, insn_valid, status_flag, fetch_contend, mem_rvalid;
	reg [15:0] insn;
	reg [31:0] pc, src_val, dst_val, r0_val, gbr_val, mem_rdata;
	wire taken, req, we, cache_prefetch_op, wb_en, upd_en, flag_we, illegal, stall;
	wire [3:0] sidx, didx, wb_idx, upd_idx;
	wire [1:0] size;
	wire [31:0] addr, wdata, wb_data, upd_data;
	int n_errors, compares, cyc;

	dtd_decoder dut_u (.clock(clock), .srst(srst), .insn_valid(insn_valid), .insn(insn), .pc(pc),
		.insn_taken_q(taken), .src_val(src_val), .dst_val(dst_val), .register_zero_val(r0_val),
		.global_base_reg(gbr_val), .status_flag(status_flag), .source_reg_field_q(sidx),
		.dest_reg_field_q(didx), .fetch_contend(fetch_contend), .mem_rdata(mem_rdata),
		.mem_rvalid(mem_rvalid), .mem_req_q(req), .mem_we_q(we), .mem_size_q(size), .mem_addr_q(addr),
		.mem_wdata_q(wdata), .prefetch_q(cache_prefetch_op), .wb_en_q(wb_en), .wb_idx_q(wb_idx), .wb_data_q(wb_data),
		.upd_en_q(upd_en), .upd_idx_q(upd_idx), .upd_data_q(upd_data), .flag_we_q(flag_we),
		.illegal_q(illegal), .stall_q(stall));

	// -----------------------------------------------------------
	// Helpers
	// -----------------------------------------------------------
	// Clock and hang guard.
	initial
	begin
		clock = 0;
		forever #10 clock = ~clock;
	end
	always @(posedge clock)
	begin
		cyc++;
		if (cyc == 3000)
		begin
			n_errors++;
			wrap_up;
		end
	end
	task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		compares++;
		if (g !== e)
		begin
			n_errors++;
			$display("BAD %s expected %h seen %h", nm, e, g);
		end
	endtask
	// Offer an instruction at a falling edge; take then holds it for up to six falling edges until the decoder takes it.
	task offer(input logic [15:0] i);
		@(negedge clock);
		insn = i;
		insn_valid = 1;
	endtask
	task take;
		repeat (6) if (taken !== 1'b1) @(negedge clock);
		insn_valid = 0;
		chk("taken", 1, taken);
	endtask
	task go(input logic [15:0] i);
		offer(i);
		take;
	endtask
	task ld(input logic [31:0] d);
		mem_rdata = d;
		mem_rvalid = 1;
		@(negedge clock);
		mem_rvalid = 0;
	endtask
	task wrap_up;
		$display("compares %0d n_errors %0d", compares, n_errors);
		if (n_errors == 0 && compares > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	// -----------------------------------------------------------
	// Scenarios
	// -----------------------------------------------------------
	task t_imm;
		go(16'he380);
		chk("imm", 32'hffffff80, wb_data);
		chk("idx", 32'h3, wb_idx);
		chk("didx", 32'h3, didx);
	endtask
	// PC-relative loads, with a dependent instruction held off meanwhile.
	task t_pcrel;
		go(16'hd2ff);
		chk("addr", 32'h000023fc, addr);
		offer(16'h6023);
		@(negedge clock);
		chk("stall", 1, stall);
		ld(32'h87654321);
		chk("wb", 32'h87654321, wb_data);
		take;
		go(16'h9201);
		chk("addr", 32'h00002002, addr);
		ld(32'h00008001);
		chk("wb", 32'hffff8001, wb_data);
	endtask
	task t_addr;
		for (int k = 0; k < 3; k++)
		begin
			go(16'h2124 + 16'(k));
			chk("addr", 32'h100 - (32'h1 << k), addr);
			chk("upd", 32'h100 - (32'h1 << k), upd_data);
			chk("we", 1, we);
		end
		go(16'h6126);
		chk("addr", 32'h11223344, addr);
		chk("upd", 32'h11223348, upd_data);
		chk("updidx", 32'h2, upd_idx);
		chk("sidx", 32'h2, sidx);
		chk("size", 32'h2, size);
		ld(32'h5);
		chk("wbidx", 32'h1, wb_idx);
		go(16'h6124);
		chk("upd", 32'h11223345, upd_data);
		ld(32'h00000080);
		chk("wb", 32'hffffff80, wb_data);
		go(16'h8125);
		chk("addr", 32'h1122334e, addr);
		chk("wdata", 32'h10, wdata);
		go(16'h1125);
		chk("addr", 32'h00000114, addr);
		go(16'hc210);
		chk("addr", 32'h00001040, addr);
		chk("wdata", 32'h10, wdata);
		go(16'h012d);
		chk("addr", 32'h11223354, addr);
		ld(32'h00008000);
		chk("wb", 32'hffff8000, wb_data);
	endtask
	task t_reg;
		go(16'hc710);
		chk("wb", 32'h00002040, wb_data);
		chk("req", 0, req);
		chk("wbidx", 32'h0, wb_idx);
		go(16'h0183);
		chk("cache_prefetch_op", 1, cache_prefetch_op);
		chk("addr", 32'h100, addr);
		go(16'h6128);
		chk("wb", 32'h11224433, wb_data);
		go(16'h6129);
		chk("wben", 0, wb_en);
		@(negedge clock);
		chk("wb", 32'h33441122, wb_data);
		go(16'h212d);
		chk("wb", 32'h33440000, wb_data);
		go(16'h0129);
		chk("wb", 32'h1, wb_data);
		chk("flagwe", 0, flag_we);
		go(16'hffff);
		chk("illegal", 1, illegal);
	endtask
	task t_contend;
		fetch_contend = 1;
		offer(16'he000);
		@(negedge clock);
		chk("stall", 1, stall);
		chk("taken", 0, taken);
		fetch_contend = 0;
		take;
	endtask

	// Reset, then the scenarios in turn.
	initial
	begin
		{insn_valid, fetch_contend, mem_rvalid, insn, mem_rdata} = 0;
		{status_flag, srst} = 2'h3;
		{pc, src_val, dst_val} = {32'h2000, 32'h11223344, 32'h100};
		{r0_val, gbr_val} = {32'h10, 32'h1000};
		repeat (3) @(negedge clock);
		srst = 0;
		t_imm;
		t_pcrel;
		t_addr;
		t_reg;
		t_contend;
		wrap_up;
	end
endmodule
